// ===== rtl/trb_consts.vh
// Constants for the tape read-block transfer logic: timing counts, codes.
// Assumes a 40 MHz clock; included by bare name from the rtl folder.
`ifndef TRB_CONSTS_VH
`define TRB_CONSTS_VH
`define TRB_CLK_MHZ 40
`define TRB_SETUP_NS 90
`define TRB_SETUP_CYC ((`TRB_SETUP_NS * `TRB_CLK_MHZ + 999) / 1000)
`define TRB_BUF_TIMEOUT_MS 75
`define TRB_BUF_TIMEOUT_CYC (`TRB_BUF_TIMEOUT_MS * `TRB_CLK_MHZ * 1000)
`define TRB_RETRY_0 2'b00
`define TRB_RETRY_5 2'b01
`define TRB_RETRY_10 2'b10
`define TRB_RETRY_15 2'b11
`define TRB_CNT_5 4'h5
`define TRB_CNT_10 4'hA
`define TRB_CNT_15 4'hF
`define TRB_BLK_DATA 2'b00
`define TRB_BLK_MARK 2'b01
`define TRB_BLK_ID 2'b10
`define TRB_BLK_NONE 2'b11
`endif

// ===== rtl/trb_edge_sync.v
// Two-stage synchroniser with rising-edge pulse for host handshake lines.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module trb_edge_sync (
    clk,
    rst_b,
    async,
    level,
    rise
);
    input clk;
    input rst_b;
    input async;
    output level;
    output rise;
    reg meta;
    reg level;
    reg prev;
    // Second stage alone feeds the edge detector to keep metastability out
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async;
            level <= meta;
            prev <= level;
        end
    end
    assign rise = level & ~prev;
endmodule

// ===== rtl/trb_read_block.v
// Read-block command engine: forward and backward, cached and uncached.
// Assumes a decoder/cache front end presenting bytes with valid strobes,
// and a host on the four-phase request/acknowledge data bus.
`timescale 1ns/1ps
`include "trb_consts.vh"
module trb_read_block #(
    parameter TIMEOUT_CYC = `TRB_BUF_TIMEOUT_CYC
) (
    clk,
    rst_b,
    readForwardBlockCmd,
    readBackwardBlockCmd,
    cachedMode,
    cacheDataMode,
    atBeginningOfTape,
    retrySelect,
    twoMarkSync,
    blkKind,
    blkStart,
    idBad,
    idDensity,
    dataIn,
    dataValid,
    dataLast,
    charError,
    endOfTapeMarker,
    hostRequested,
    transferAcknowledge,
    hostStop,
    dataOut,
    dataOe,
    transferRequest,
    busy,
    tapeForward,
    tapeReverse,
    rereadReq,
    readAheadEn,
    endOfDataPulse,
    overrunStatus,
    crcError,
    dataCheckFlag,
    tapeMarkStatus,
    blockPulse,
    rejectFlag,
    identificationBurstFlag,
    density,
    statusValid
);
    input clk;
    input rst_b;
    input readForwardBlockCmd;
    input readBackwardBlockCmd;
    input cachedMode;
    input cacheDataMode;
    input atBeginningOfTape;
    input [1:0] retrySelect;
    input twoMarkSync;
    input [1:0] blkKind;
    input blkStart;
    input idBad;
    input [1:0] idDensity;
    input [7:0] dataIn;
    input dataValid;
    input dataLast;
    input charError;
    input endOfTapeMarker;
    input hostRequested;
    input transferAcknowledge;
    input hostStop;
    output [7:0] dataOut;
    output dataOe;
    output transferRequest;
    output busy;
    output tapeForward;
    output tapeReverse;
    output rereadReq;
    output readAheadEn;
    output endOfDataPulse;
    output overrunStatus;
    output crcError;
    output dataCheckFlag;
    output tapeMarkStatus;
    output blockPulse;
    output rejectFlag;
    output identificationBurstFlag;
    output [1:0] density;
    output statusValid;

    localparam S_IDLE = 7'b0000001;
    localparam S_ID = 7'b0000010;
    localparam S_WAITBLK = 7'b0000100;
    localparam S_SETUP = 7'b0001000;
    localparam S_REQ = 7'b0010000;
    localparam S_DRAIN = 7'b0100000;
    localparam S_END = 7'b1000000;
    localparam SETUP_N = `TRB_SETUP_CYC;

    reg [6:0] state;
    reg [7:0] dataOut;
    reg dataOe;
    reg transferRequest;
    reg busy;
    reg tapeForward;
    reg tapeReverse;
    reg rereadReq;
    reg readAheadEn;
    reg endOfDataPulse;
    reg overrunStatus;
    reg crcError;
    reg dataCheckFlag;
    reg tapeMarkStatus;
    reg blockPulse;
    reg rejectFlag;
    reg identificationBurstFlag;
    reg [1:0] density;
    reg statusValid;
    reg [7:0] holdByte;
    reg holdFull;
    reg hostDone;
    reg eodSeen;
    reg backward;
    reg [2:0] setupCnt;
    reg [3:0] retryCnt;
    reg [31:0] waitCnt;
    reg markSeen;
    reg failedBlk;
    reg markHalt;
    wire ackLevel;
    wire ackRise;
    wire stopLevel;
    wire stopRise;

    // Acknowledge and stop are taken from the host clock-free; resync here
    trb_edge_sync ackSync (
        .clk(clk),
        .rst_b(rst_b),
        .async(transferAcknowledge),
        .level(ackLevel),
        .rise(ackRise)
    );
    trb_edge_sync stopSync (
        .clk(clk),
        .rst_b(rst_b),
        .async(hostStop),
        .level(stopLevel),
        .rise(stopRise)
    );

    // Retry limit from the two-bit selection
    function [3:0] retryLimit;
        input [1:0] sel;
        begin
            case (sel)
                `TRB_RETRY_5: retryLimit = `TRB_CNT_5;
                `TRB_RETRY_10: retryLimit = `TRB_CNT_10;
                `TRB_RETRY_15: retryLimit = `TRB_CNT_15;
                default: retryLimit = 4'h0;
            endcase
        end
    endfunction

    wire taken = ackRise | stopRise;
    wire timedOut = cachedMode && (waitCnt >= TIMEOUT_CYC - 1);

    // Main command sequencer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_IDLE;
            dataOut <= 8'h00;
            dataOe <= 1'b0;
            transferRequest <= 1'b0;
            busy <= 1'b0;
            tapeForward <= 1'b0;
            tapeReverse <= 1'b0;
            rereadReq <= 1'b0;
            readAheadEn <= 1'b0;
            endOfDataPulse <= 1'b0;
            overrunStatus <= 1'b0;
            crcError <= 1'b0;
            dataCheckFlag <= 1'b0;
            tapeMarkStatus <= 1'b0;
            blockPulse <= 1'b0;
            rejectFlag <= 1'b0;
            identificationBurstFlag <= 1'b0;
            density <= 2'b00;
            statusValid <= 1'b0;
            holdByte <= 8'h00;
            holdFull <= 1'b0;
            hostDone <= 1'b0;
            eodSeen <= 1'b0;
            backward <= 1'b0;
            setupCnt <= 3'h0;
            retryCnt <= 4'h0;
            waitCnt <= 32'h00000000;
            markSeen <= 1'b0;
            failedBlk <= 1'b0;
            markHalt <= 1'b0;
        end else begin
            endOfDataPulse <= 1'b0;
            blockPulse <= 1'b0;
            rereadReq <= 1'b0;
            // Read-ahead runs in cached mode after a forward read until end of tape or marks halt it
            if (!cachedMode || endOfTapeMarker) begin
                readAheadEn <= 1'b0;
            end
            // Byte holding stage: one byte beyond the one on the bus
            if (dataValid && (state == S_SETUP || state == S_REQ ||
                    state == S_WAITBLK || state == S_DRAIN)) begin
                if (charError) begin
                    crcError <= 1'b1;
                end
                if (hostDone) begin
                    holdFull <= holdFull;
                end else if (holdFull && state != S_DRAIN) begin
                    // A drain in this cycle frees the slot, so only other states overrun
                    overrunStatus <= 1'b1;
                    crcError <= 1'b1;
                    dataCheckFlag <= 1'b1;
                end else begin
                    holdByte <= dataIn;
                    holdFull <= 1'b1;
                end
                if (dataLast) begin
                    eodSeen <= 1'b1;
                    endOfDataPulse <= 1'b1;
                end
            end
            case (state)
                S_IDLE: begin
                    statusValid <= statusValid & ~(readForwardBlockCmd | readBackwardBlockCmd);
                    if (readBackwardBlockCmd && (atBeginningOfTape ||
                            (cachedMode && cacheDataMode))) begin
                        rejectFlag <= 1'b1;
                        statusValid <= 1'b1;
                    end else if (readForwardBlockCmd || readBackwardBlockCmd) begin
                        busy <= 1'b1;
                        backward <= readBackwardBlockCmd;
                        tapeForward <= readForwardBlockCmd;
                        tapeReverse <= readBackwardBlockCmd;
                        rejectFlag <= 1'b0;
                        overrunStatus <= 1'b0;
                        crcError <= 1'b0;
                        dataCheckFlag <= 1'b0;
                        tapeMarkStatus <= 1'b0;
                        holdFull <= 1'b0;
                        hostDone <= 1'b0;
                        eodSeen <= 1'b0;
                        retryCnt <= 4'h0;
                        failedBlk <= 1'b0;
                        markHalt <= 1'b0;
                        if (readForwardBlockCmd && atBeginningOfTape) begin
                            identificationBurstFlag <= 1'b1;
                            state <= S_ID;
                        end else begin
                            state <= S_WAITBLK;
                        end
                    end
                end
                S_ID: begin
                    if (blkStart) begin
                        identificationBurstFlag <= 1'b0;
                        if (idBad) begin
                            rejectFlag <= 1'b1;
                            dataCheckFlag <= 1'b1;
                            state <= S_END;
                        end else begin
                            density <= idDensity;
                            state <= S_WAITBLK;
                        end
                    end
                end
                S_WAITBLK: begin
                    if (blkStart) begin
                        case (blkKind)
                            `TRB_BLK_MARK: begin
                                tapeMarkStatus <= 1'b1;
                                blockPulse <= 1'b1;
                                if (cachedMode && (!twoMarkSync || markSeen)) begin
                                    readAheadEn <= 1'b0;
                                    markHalt <= 1'b1;
                                end
                                markSeen <= ~markSeen & twoMarkSync;
                                state <= S_END;
                            end
                            `TRB_BLK_ID: begin
                                dataCheckFlag <= backward;
                                state <= S_END;
                            end
                            default: begin
                                markSeen <= 1'b0;
                                state <= S_DRAIN;
                            end
                        endcase
                    end
                end
                S_DRAIN: begin
                    // After a stop the rest of the block is still checked up to end of data
                    if (eodSeen && (hostDone || !holdFull)) begin
                        state <= S_END;
                    end else if (holdFull && !hostDone) begin
                        dataOut <= holdByte;
                        dataOe <= 1'b1;
                        holdFull <= dataValid;
                        setupCnt <= 3'h0;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    setupCnt <= setupCnt + 3'h1;
                    if (setupCnt == SETUP_N[2:0] - 3'h1 && !ackLevel && !stopLevel) begin
                        transferRequest <= 1'b1;
                        waitCnt <= 32'h00000000;
                        state <= S_REQ;
                    end
                end
                S_REQ: begin
                    waitCnt <= waitCnt + 32'h00000001;
                    if (taken) begin
                        transferRequest <= 1'b0;
                        hostDone <= stopRise;
                        state <= S_DRAIN;
                    end else if (timedOut) begin
                        transferRequest <= 1'b0;
                        rejectFlag <= 1'b1;
                        hostDone <= 1'b1;
                        state <= S_DRAIN;
                    end
                end
                S_END: begin
                    // Whole block checked; retry in read-ahead only for unrequested records
                    if (cachedMode && !hostRequested && crcError && !backward &&
                            retryCnt < retryLimit(retrySelect)) begin
                        retryCnt <= retryCnt + 4'h1;
                        rereadReq <= 1'b1;
                        crcError <= 1'b0;
                        holdFull <= 1'b0;
                        eodSeen <= 1'b0;
                        hostDone <= 1'b0;
                        state <= S_WAITBLK;
                    end else if (!ackLevel && !stopLevel) begin
                        if (cachedMode && crcError && !hostRequested) begin
                            failedBlk <= 1'b1;
                        end
                        dataCheckFlag <= dataCheckFlag | crcError | failedBlk;
                        tapeForward <= 1'b0;
                        tapeReverse <= 1'b0;
                        dataOe <= 1'b0;
                        statusValid <= 1'b1;
                        busy <= 1'b0;
                        readAheadEn <= cachedMode & ~backward & ~endOfTapeMarker &
                                ~markHalt;
                        state <= S_IDLE;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== testbench/trb_read_block_asserts.sv
// Checker for the read-block engine: byte handshake and command timing.
// Assumes it is bound onto trb_read_block and sees only its ports.
`timescale 1ns/1ps
module trb_read_block_asserts (
    input logic clk,
    input logic rst_b,
    input logic readForwardBlockCmd,
    input logic readBackwardBlockCmd,
    input logic cachedMode,
    input logic atBeginningOfTape,
    input logic transferAcknowledge,
    input logic hostStop,
    input logic [7:0] dataOut,
    input logic dataOe,
    input logic transferRequest,
    input logic busy,
    input logic tapeForward,
    input logic tapeReverse,
    input logic overrunStatus,
    input logic crcError,
    input logic dataCheckFlag,
    input logic statusValid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Byte must settle four cycles (100 ns) before the request goes up
    chk_req_setup: assert property ($rose(transferRequest) |-> dataOe && $past(dataOe, 4) && $past(dataOut, 4) == dataOut)
        else $error("request raised without byte setup time");
    chk_data_hold: assert property (transferRequest |-> dataOe && $stable(dataOut))
        else $error("byte changed while request high");
    // Synchroniser adds two cycles, so the drop is bounded, not immediate
    chk_req_drop: assert property ($rose(transferAcknowledge || hostStop) && transferRequest |-> ##[1:4] !transferRequest)
        else $error("request not dropped after host answer");
    chk_one_answer: assert property ((transferAcknowledge || hostStop) |=> !$rose(transferRequest))
        else $error("new request while host answer still high");
    chk_fwd_start: assert property (readForwardBlockCmd && !busy && !cachedMode |=> busy && tapeForward)
        else $error("forward command did not start tape");
    chk_bwd_start: assert property (readBackwardBlockCmd && !busy && !cachedMode && !atBeginningOfTape |=> busy && tapeReverse)
        else $error("backward command did not reverse tape");
    chk_bot_reject: assert property (readBackwardBlockCmd && !busy && atBeginningOfTape |=> !busy [*4])
        else $error("backward at load point went busy");
    chk_end_order: assert property ($fell(busy) |-> statusValid && !tapeForward && !tapeReverse)
        else $error("busy cleared before tape stop and status");
    chk_one_way: assert property (!(tapeForward && tapeReverse))
        else $error("tape driven both ways");
    chk_req_busy: assert property (transferRequest |-> busy)
        else $error("request outside a command");
    chk_overrun_flags: assert property ($fell(busy) && overrunStatus |-> crcError && dataCheckFlag)
        else $error("overrun without crc and data check");

    cover property ($fell(transferRequest));
    cover property ($fell(busy) && overrunStatus);
    cover property (readBackwardBlockCmd && atBeginningOfTape);
endmodule
bind trb_read_block trb_read_block_asserts i_chk (.*);

// ===== testbench/trb_host_model.sv
// Host controller model: answers each transfer request with ack or stop.
// Assumes the device drives dataOut and raises transferRequest per byte.
`timescale 1ns/1ps
module trb_host_model (
    input logic clk,
    input logic rst_b,
    input logic transferRequest,
    input logic [7:0] dataOut,
    input int dly,
    input int stopAt,
    output logic transferAcknowledge,
    output logic hostStop,
    output int nRx
);
    logic [7:0] rx [0:15];
    logic held;
    int cnt;

    // Own delay counter only; request spacing is never used for timing
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            transferAcknowledge <= 1'h0;
            hostStop <= 1'h0;
            held <= 1'h0;
            nRx <= 0;
            cnt <= 0;
        end else if (!held) begin
            if (transferRequest && cnt >= dly) begin
                rx[nRx[3:0]] <= dataOut;
                nRx <= nRx + 1;
                if (nRx + 1 == stopAt) hostStop <= 1'h1;
                else transferAcknowledge <= 1'h1;
                held <= 1'h1;
                cnt <= 0;
            end else if (transferRequest) cnt <= cnt + 1;
        end else if (!transferRequest) begin
            // Release only after the request has dropped
            if (cnt >= dly) begin
                transferAcknowledge <= 1'h0;
                hostStop <= 1'h0;
                held <= 1'h0;
                cnt <= 0;
            end else cnt <= cnt + 1;
        end
    end
endmodule

// ===== testbench/trb_read_block_bench.sv
// Bench for the read-block engine: front-end feed, host model, checks.
// Assumes rtl on the include path; the buffered timeout is cut to 50 cycles.
`timescale 1ns/1ps
`include "trb_consts.vh"
module trb_read_block_bench;
    logic clk = 0, rst_b = 0, readForwardBlockCmd = 0, readBackwardBlockCmd = 0;
    logic cachedMode = 0, cacheDataMode = 0, atBeginningOfTape = 0, twoMarkSync = 0;
    logic blkStart = 0, idBad = 0, dataValid = 0, dataLast = 0, charError = 0;
    logic endOfTapeMarker = 0, hostRequested = 0;
    logic [1:0] retrySelect = 0, blkKind = 0, idDensity = 0;
    logic [7:0] dataIn = 0;
    wire transferAcknowledge, hostStop, dataOe, transferRequest, busy, tapeForward;
    wire tapeReverse, rereadReq, readAheadEn, endOfDataPulse, overrunStatus, crcError;
    wire dataCheckFlag, tapeMarkStatus, blockPulse, rejectFlag, identificationBurstFlag;
    wire statusValid;
    wire [7:0] dataOut;
    wire [1:0] density;
    int dly = 1, stopAt = 0, nRx, fail_count = 0, n_checks = 0, cyc = 0, base, b0;
    int eodCnt = 0, blkCnt = 0, reqCnt = 0, revSeen = 0, idSeen = 0, rrCnt = 0;
    logic reqPrev = 0;

    always #12.5 clk = ~clk;

    trb_read_block #(.TIMEOUT_CYC(50)) i_dut (.*);
    trb_host_model i_host (.*);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Pulses last one cycle, so they are counted on every edge
    always @(posedge clk) begin
        cyc++;
        reqPrev <= transferRequest;
        if (endOfDataPulse === 1'h1) eodCnt++;
        if (blockPulse === 1'h1) blkCnt++;
        if (rereadReq === 1'h1) rrCnt++;
        if (transferRequest === 1'h1 && reqPrev !== 1'h1) reqCnt++;
        if (tapeReverse === 1'h1) revSeen++;
        if (identificationBurstFlag === 1'h1) idSeen++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic cmd(input logic bwd);
        @(posedge clk);
        readForwardBlockCmd <= !bwd;
        readBackwardBlockCmd <= bwd;
        @(posedge clk);
        readForwardBlockCmd <= 1'h0;
        readBackwardBlockCmd <= 1'h0;
    endtask

    task automatic blk(input logic [1:0] k);
        @(posedge clk);
        blkKind <= k;
        blkStart <= 1'h1;
        @(posedge clk);
        blkStart <= 1'h0;
    endtask

    task automatic feed(input logic [7:0] d, input logic last, input logic err, input int gap);
        @(posedge clk);
        dataIn <= d;
        dataValid <= 1'h1;
        dataLast <= last;
        charError <= err;
        @(posedge clk);
        dataValid <= 1'h0;
        dataLast <= 1'h0;
        charError <= 1'h0;
        repeat (gap) @(posedge clk);
    endtask

    // Waits for byte n to be taken and the host answer released
    task automatic waitRx(input int n);
        for (int i = 0; i < 300 && (nRx != n || (transferAcknowledge | hostStop) !== 1'h0); i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task automatic waitIdle();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 2000 && busy !== 1'h0; i++) @(posedge clk);
        @(posedge clk);
    endtask

    // One data block; each byte offered after the previous handshake ends
    task automatic runBlock(input logic bwd, input int n, input logic [7:0] s);
        base = nRx;
        cmd(bwd);
        blk(`TRB_BLK_DATA);
        for (int k = 0; k < n; k++) begin
            feed(8'(s + 8'h11 * k), k == n - 1, 1'h0, 0);
            waitRx(base + k + 1);
        end
        waitIdle();
        for (int k = 0; k < n; k++) check(i_host.rx[base + k], 8'(s + 8'h11 * k));
        check(statusValid, 8'h1);
        check(overrunStatus, 8'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        // Forward with a quick host, then backward with a slow one
        runBlock(1'h0, 3, 8'hA5);
        check(8'(eodCnt), 8'h1);
        dly = 10;
        runBlock(1'h1, 3, 8'h3C);
        check(8'(revSeen > 0), 8'h1);
        check(8'(eodCnt), 8'h2);
        // Early stop; a bad byte after it still shows in the status
        dly = 1;
        base = nRx;
        stopAt = base + 1;
        cmd(1'h0);
        blk(`TRB_BLK_DATA);
        feed(8'h5A, 1'h0, 1'h0, 0);
        waitRx(base + 1);
        feed(8'h6B, 1'h0, 1'h1, 4);
        feed(8'h7C, 1'h1, 1'h0, 4);
        waitIdle();
        check(8'(nRx - base), 8'h1);
        check(i_host.rx[base], 8'h5A);
        check(dataCheckFlag, 8'h1);
        stopAt = 0;
        // Tape mark: block pulse, status, no request
        b0 = blkCnt;
        base = reqCnt;
        cmd(1'h0);
        blk(`TRB_BLK_MARK);
        waitIdle();
        check(tapeMarkStatus, 8'h1);
        check(8'(blkCnt - b0), 8'h1);
        check(8'(reqCnt - base), 8'h0);
        // Load point: identification area sets density, then a tape mark
        atBeginningOfTape <= 1'h1;
        idDensity <= 2'h2;
        cmd(1'h0);
        atBeginningOfTape <= 1'h0;
        blk(`TRB_BLK_ID);
        blk(`TRB_BLK_MARK);
        waitIdle();
        check(density, 8'h2);
        check(8'(idSeen > 0), 8'h1);
        // Host far too slow: bytes are lost and never resent
        dly = 30;
        base = nRx;
        cmd(1'h0);
        blk(`TRB_BLK_DATA);
        for (int k = 0; k < 4; k++) feed(8'(8'h81 + 8'h11 * k), k == 3, 1'h0, 1);
        waitIdle();
        check(overrunStatus, 8'h1);
        check(crcError, 8'h1);
        check(dataCheckFlag, 8'h1);
        check(8'(nRx - base < 4), 8'h1);
        // Cached read ahead: a bad block is reread once, end of tape halts it
        dly = 1;
        cachedMode <= 1'h1;
        retrySelect <= `TRB_RETRY_5;
        base = nRx;
        cmd(1'h0);
        blk(`TRB_BLK_DATA);
        feed(8'h42, 1'h1, 1'h1, 0);
        waitRx(base + 1);
        blk(`TRB_BLK_DATA);
        feed(8'h42, 1'h1, 1'h0, 0);
        waitIdle();
        check(8'(rrCnt), 8'h1);
        check(crcError, 8'h0);
        check(readAheadEn, 8'h1);
        endOfTapeMarker <= 1'h1;
        repeat (3) @(posedge clk);
        check(readAheadEn, 8'h0);
        endOfTapeMarker <= 1'h0;
        // Backward refused at load point and in cache data mode
        dly = 1;
        for (int i = 0; i < 2; i++) begin
            atBeginningOfTape <= (i == 0);
            cachedMode <= (i == 1);
            cacheDataMode <= (i == 1);
            if (i == 1) begin
                // Forward still taken in cache data mode; one mark halts read ahead
                cmd(1'h0);
                blk(`TRB_BLK_MARK);
                waitIdle();
                check(rejectFlag, 8'h0);
                check(readAheadEn, 8'h0);
            end
            cmd(1'h1);
            repeat (6) @(posedge clk);
            check(rejectFlag, 8'h1);
            check(busy, 8'h0);
        end
        summarize();
    end
endmodule
